/* verilog/prefetch_pkg.sv */
// Shared constants and types for the instruction prefetch queue
package prefetch_pkg;

    // ------------------------------------------------------------------
    // Queue geometry
    // ------------------------------------------------------------------
    localparam int WORD_WIDTH   = 16;
    localparam int QUEUE_WORDS  = 3;
    localparam int FIFO_DEPTH   = 16;
    localparam int CREDIT_RESET = 3;

    // ------------------------------------------------------------------
    // Queue status pin codes
    // ------------------------------------------------------------------
    localparam logic [1:0] STATUS_IDLE    = 2'h0;
    localparam logic [1:0] STATUS_ADVANCE = 2'h1;
    localparam logic [1:0] STATUS_START   = 2'h2;
    localparam logic [1:0] STATUS_BOTH    = 2'h3;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] FETCH_PTR_RESET = 16'h0000;
    localparam logic [15:0] WORD_RESET      = 16'h0000;
    localparam logic [7:0]  BYTE_RESET      = 8'h00;

    // ------------------------------------------------------------------
    // Control states
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {
        ST_LOAD_VECTOR = 1'b0,
        ST_RUN         = 1'b1
    } queue_state_type;

endpackage : prefetch_pkg

/* verilog/word_fifo.sv */
// Parameterised valid/ready FIFO for returned program words
`timescale 1ns/1ps

module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    // Filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             full;
    logic             empty;

    // ------------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------------
    assign empty     = (wr_ptr == rd_ptr);
    assign full      = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = store[rd_ptr[AW-1:0]];

    // ------------------------------------------------------------------
    // Pointers and storage
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            wr_ptr <= '0;
        end else if (in_valid && !full) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (in_valid && !full) begin
            store[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rd_ptr <= '0;
        end else if (out_ready && !empty) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end

endmodule : word_fifo

/* verilog/byte_selector.sv */
// Picks opcode and two following bytes from the head words by alignment
`timescale 1ns/1ps

module byte_selector (
    // Head words, big-endian byte order
    input  wire logic [15:0] head_word,
    input  wire logic [15:0] next_word,
    // Alignment of the opcode
    input  wire logic        odd,
    // Selected bytes
    output logic [7:0]       opcode,
    output logic [7:0]       byte1,
    output logic [7:0]       byte2
);

    // Even address sits in the high half of a word
    always_comb begin
        if (odd) begin
            opcode = head_word[7:0];
            byte1  = next_word[15:8];
            byte2  = next_word[7:0];
        end else begin
            opcode = head_word[15:8];
            byte1  = head_word[7:0];
            byte2  = next_word[15:8];
        end
    end

endmodule : byte_selector

/* verilog/instruction_prefetch_queue.sv */
// Instruction prefetch queue: fetch, alignment, byte routing and status pins
//
// Overview of operation
// - Two queue words plus one holding buffer word
// - Fetch aligned words only, no misalignment penalty
// - Odd reset vector: fill from word below
// - Present opcode and two following bytes
// - Issue fetches to refill consumed queue space
// - Execution unit advances and toggles; queue keeps alignment
// - Selector routes bytes and exposes alignment
// - Execution sequence independent of alignment
// - One fetch per two bytes; odd gets optional
// - Aligned odd instruction: optional cycle is free
// - Misaligned odd instruction: optional cycle fetches
// - Narrow memory stretches fetching optional cycle via freeze
// - Two status pins report movement and start
`timescale 1ns/1ps

module instruction_prefetch_queue #(
    parameter int WORD_WIDTH = prefetch_pkg::WORD_WIDTH,
    parameter int FIFO_DEPTH = prefetch_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  nrst,
    // Start address, sampled once after reset release
    input  wire logic [15:0]           reset_vector,
    // Program fetch requests to the bus integration module
    output logic                       fetch_valid,
    input  wire logic                  fetch_ready,
    output logic [15:0]                fetch_addr,
    // Returned program words
    input  wire logic                  mem_valid,
    output logic                       mem_ready,
    input  wire logic [WORD_WIDTH-1:0] mem_data,
    // Core clock freeze from the bus integration module
    input  wire logic                  core_freeze,
    // Execution unit controls
    input  wire logic                  exec_start,
    input  wire logic                  exec_advance,
    input  wire logic                  exec_toggle_align,
    input  wire logic                  exec_optional,
    // Execution unit inputs
    output logic                       queue_ready,
    output logic [7:0]                 opcode,
    output logic [7:0]                 operand1,
    output logic [7:0]                 operand2,
    output logic                       align_odd,
    output logic                       optional_fetch,
    output logic                       optional_free,
    // Development system status
    output logic [1:0]                 queue_status_pins
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    prefetch_pkg::queue_state_type state;

    logic [WORD_WIDTH-1:0] qword [prefetch_pkg::QUEUE_WORDS];
    logic [1:0]            count;
    logic [1:0]            next_count;
    logic [1:0]            kept;
    logic [2:0]            credits;
    logic [15:0]           fetch_ptr;
    logic                  start_odd;
    logic                  live;
    logic                  optional_adv;
    logic                  advance;
    logic                  fetch_take;
    logic                  fifo_valid;
    logic                  fifo_take;
    logic [WORD_WIDTH-1:0] fifo_data;
    logic [7:0]            sel_opcode;
    logic [7:0]            sel_byte1;
    logic [7:0]            sel_byte2;
    logic                  cur_odd;

    // ------------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------------
    // Vector is caught by the first clocked edge after release, never in reset
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state <= prefetch_pkg::ST_LOAD_VECTOR;
        end else begin
            unique case (state)
                prefetch_pkg::ST_LOAD_VECTOR: state <= prefetch_pkg::ST_RUN;
                prefetch_pkg::ST_RUN:         state <= prefetch_pkg::ST_RUN;
            endcase
        end
    end

    // Frozen core clocks stop all queue motion
    assign live = (state == prefetch_pkg::ST_RUN) && !core_freeze;

    // ------------------------------------------------------------------
    // Optional cycle decision
    // ------------------------------------------------------------------
    // Alignment at the instruction start decides the optional cycle
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            start_odd <= 1'b0;
        end else if (live && exec_start) begin
            start_odd <= cur_odd;
        end
    end

    // Execution unit does not track alignment, so the queue decides
    assign optional_adv   = live && exec_optional && start_odd;
    assign optional_fetch = exec_optional && start_odd;
    assign optional_free  = exec_optional && !start_odd;
    assign advance        = live && (exec_advance || optional_adv) && (count != 2'h0);

    // ------------------------------------------------------------------
    // Alignment tracking
    // ------------------------------------------------------------------
    // Odd vector starts on the low half of the word below it
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cur_odd <= 1'b0;
        end else if (state == prefetch_pkg::ST_LOAD_VECTOR) begin
            cur_odd <= reset_vector[0];
        end else if (live && exec_toggle_align) begin
            cur_odd <= !cur_odd;
        end
    end

    // ------------------------------------------------------------------
    // Fetch issue
    // ------------------------------------------------------------------
    // Credits count queue slots not yet claimed by a fetch
    assign fetch_valid = live && (credits != 3'h0);
    assign fetch_addr  = fetch_ptr;
    assign fetch_take  = fetch_valid && fetch_ready;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            fetch_ptr <= prefetch_pkg::FETCH_PTR_RESET;
        end else if (state == prefetch_pkg::ST_LOAD_VECTOR) begin
            fetch_ptr <= {reset_vector[15:1], 1'b0};
        end else if (fetch_take) begin
            fetch_ptr <= fetch_ptr + 16'h0002;
        end
    end

    // Each advance frees one slot, so one word fetched per two bytes
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            credits <= 3'(prefetch_pkg::CREDIT_RESET);
        end else begin
            credits <= credits - {2'h0, fetch_take} + {2'h0, advance};
        end
    end

    // ------------------------------------------------------------------
    // Return buffering
    // ------------------------------------------------------------------
    // Credits bound traffic to three words, so the FIFO only absorbs
    // bus latency; it never fills, so it never stalls the bus even if the queue stops draining
    word_fifo #(
        .WIDTH (WORD_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_return_fifo (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .in_valid  (mem_valid),
        .in_ready  (mem_ready),
        .in_data   (mem_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_take),
        .out_data  (fifo_data)
    );

    // ------------------------------------------------------------------
    // Queue words and holding buffer
    // ------------------------------------------------------------------
    assign kept      = count - {1'b0, advance};
    assign fifo_take = live && fifo_valid && (kept != 2'(prefetch_pkg::QUEUE_WORDS));
    assign next_count = kept + {1'b0, fifo_take};

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            count <= 2'h0;
        end else begin
            count <= next_count;
        end
    end

    // Shift on advance, then land the new word in the first empty slot
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            for (int i = 0; i < prefetch_pkg::QUEUE_WORDS; i++) begin
                qword[i] <= prefetch_pkg::WORD_RESET;
            end
        end else begin
            for (int i = 0; i < prefetch_pkg::QUEUE_WORDS; i++) begin
                if (fifo_take && (kept == 2'(i))) begin
                    qword[i] <= fifo_data;
                end else if (advance && (i < prefetch_pkg::QUEUE_WORDS - 1)) begin
                    // Wrapped index keeps the unrolled read in range; the last slot never shifts
                    qword[i] <= qword[(i + 1) % prefetch_pkg::QUEUE_WORDS];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Byte routing to the execution unit
    // ------------------------------------------------------------------
    byte_selector u_selector (
        .head_word (qword[0]),
        .next_word (qword[1]),
        .odd       (cur_odd),
        .opcode    (sel_opcode),
        .byte1     (sel_byte1),
        .byte2     (sel_byte2)
    );

    // Registered bytes; same latency on both alignments
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            opcode   <= prefetch_pkg::BYTE_RESET;
            operand1 <= prefetch_pkg::BYTE_RESET;
            operand2 <= prefetch_pkg::BYTE_RESET;
        end else begin
            opcode   <= sel_opcode;
            operand1 <= sel_byte1;
            operand2 <= sel_byte2;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            align_odd <= 1'b0;
        end else begin
            align_odd <= cur_odd;
        end
    end

    // Two words cover three bytes from either half of the head word
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            queue_ready <= 1'b0;
        end else begin
            queue_ready <= (next_count >= 2'h2);
        end
    end

    // ------------------------------------------------------------------
    // Development status pins
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            queue_status_pins <= prefetch_pkg::STATUS_IDLE;
        end else if (advance && live && exec_start) begin
            queue_status_pins <= prefetch_pkg::STATUS_BOTH;
        end else if (live && exec_start) begin
            queue_status_pins <= prefetch_pkg::STATUS_START;
        end else if (advance) begin
            queue_status_pins <= prefetch_pkg::STATUS_ADVANCE;
        end else begin
            queue_status_pins <= prefetch_pkg::STATUS_IDLE;
        end
    end

endmodule : instruction_prefetch_queue

/* tb/prog_mem_model.sv */
// Program memory partner behind the bus integration module
`timescale 1ns/1ps

module prog_mem_model (
    // Clock, reset and pacing
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        slow,
    // Fetch requests
    input  wire logic        fetch_valid,
    output logic             fetch_ready,
    input  wire logic [15:0] fetch_addr,
    // Returned words
    output logic             mem_valid,
    input  wire logic        mem_ready,
    output logic [15:0]      mem_data
);
    logic [15:0] pend[$];
    logic        tick = 1'b0;
    logic        nv;

    // ----------------------------------------------------------------
    // One assembled word per fetch, in order; slow mode halves the pace
    // ----------------------------------------------------------------
    always @(posedge sys_clk) begin
        tick <= !tick;
        if (!nrst) begin
            pend.delete();
            fetch_ready <= 1'b0;
            mem_valid   <= 1'b0;
            mem_data    <= 16'h0000;
        end else begin
            if (mem_valid && mem_ready) pend.delete(0);
            if (fetch_valid && fetch_ready) pend.push_back(fetch_addr);
            // Once offered, a word stays until taken
            nv = pend.size() > 0 && (!slow || tick || (mem_valid && !mem_ready));
            fetch_ready <= !slow || tick;
            mem_valid   <= nv;
            // Idle data is scrambled so a stale word never passes as valid
            mem_data    <= nv ? {pend[0][7:0], pend[0][15:8] ^ 8'h5A} : ~mem_data;
        end
    end
endmodule : prog_mem_model

/* tb/prefetch_chk.sv */
// Port-level assertions for the instruction prefetch queue
`timescale 1ns/1ps

module prefetch_chk (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        nrst,
    // Fetch and freeze
    input wire logic        fetch_valid,
    input wire logic        fetch_ready,
    input wire logic [15:0] fetch_addr,
    input wire logic        core_freeze,
    // Execution controls
    input wire logic        exec_start,
    input wire logic        exec_advance,
    input wire logic        exec_toggle_align,
    input wire logic        exec_optional,
    // Queue outputs
    input wire logic        queue_ready,
    input wire logic        align_odd,
    input wire logic        optional_fetch,
    input wire logic        optional_free,
    input wire logic [1:0]  queue_status_pins
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_next_fetch;
        fetch_valid && fetch_ready ##1 fetch_valid;
    endsequence

    a_fetch_aligned: assert property (fetch_valid |-> fetch_addr[0] == 1'b0)
        else $error("fetch address not word aligned");
    a_addr_step: assert property (s_next_fetch |-> fetch_addr == $past(fetch_addr) + 16'h0002)
        else $error("fetch address did not step by one word");
    a_request_hold: assert property (fetch_valid && !fetch_ready |=> !fetch_valid || $stable(fetch_addr))
        else $error("pending fetch address changed");
    a_freeze_stop: assert property (core_freeze |-> !fetch_valid)
        else $error("fetch issued while core frozen");
    a_reset_quiet: assert property ($rose(nrst) |-> !fetch_valid ##[1:3] (fetch_valid || core_freeze))
        else $error("queue fill did not start after reset");
    a_status_start: assert property (exec_start && !exec_advance && !core_freeze
                                     |=> queue_status_pins == prefetch_pkg::STATUS_START)
        else $error("start code missing");
    a_status_adv: assert property (exec_advance && !exec_start && queue_ready && !core_freeze
                                   |=> queue_status_pins == prefetch_pkg::STATUS_ADVANCE)
        else $error("advance code missing");
    a_status_idle: assert property (!(exec_start || exec_advance || exec_optional)
                                    |=> queue_status_pins == prefetch_pkg::STATUS_IDLE)
        else $error("status not idle without controls");
    a_align_flip: assert property (exec_toggle_align && !core_freeze |-> ##2 align_odd != $past(align_odd))
        else $error("alignment did not toggle");
    a_opt_split: assert property (exec_optional |-> optional_fetch != optional_free)
        else $error("optional cycle not exactly one kind");
    a_opt_quiet: assert property (!exec_optional |-> !optional_fetch && !optional_free)
        else $error("optional flag without optional cycle");
endmodule : prefetch_chk

bind instruction_prefetch_queue prefetch_chk chk_u (
    .sys_clk(sys_clk), .nrst(nrst), .fetch_valid(fetch_valid), .fetch_ready(fetch_ready),
    .fetch_addr(fetch_addr), .core_freeze(core_freeze), .exec_start(exec_start),
    .exec_advance(exec_advance), .exec_toggle_align(exec_toggle_align), .exec_optional(exec_optional),
    .queue_ready(queue_ready), .align_odd(align_odd), .optional_fetch(optional_fetch),
    .optional_free(optional_free), .queue_status_pins(queue_status_pins)
);

/* tb/instruction_prefetch_queue_tb_top.sv */
// Self-checking testbench for the instruction prefetch queue
`timescale 1ns/1ps

`define CHK(what, exp, got) \
    begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
    $display("[FAIL] %s expected %h seen %h", what, exp, got); end end

module instruction_prefetch_queue_tb_top;
    logic        sys_clk, nrst, slow, core_freeze, fetch_valid, fetch_ready, mem_valid, mem_ready;
    logic        exec_start, exec_advance, exec_toggle_align, exec_optional;
    logic        queue_ready, align_odd, optional_fetch, optional_free;
    logic [15:0] reset_vector, fetch_addr, mem_data, first_addr;
    logic [7:0]  opcode, operand1, operand2;
    logic [1:0]  queue_status_pins;
    int          n_fail, samples_checked, n_fetch;

    instruction_prefetch_queue #(.WORD_WIDTH(16), .FIFO_DEPTH(16)) dut_u (
        .sys_clk(sys_clk), .nrst(nrst), .reset_vector(reset_vector), .fetch_valid(fetch_valid),
        .fetch_ready(fetch_ready), .fetch_addr(fetch_addr), .mem_valid(mem_valid), .mem_ready(mem_ready),
        .mem_data(mem_data), .core_freeze(core_freeze), .exec_start(exec_start),
        .exec_advance(exec_advance), .exec_toggle_align(exec_toggle_align), .exec_optional(exec_optional),
        .queue_ready(queue_ready), .opcode(opcode), .operand1(operand1), .operand2(operand2),
        .align_odd(align_odd), .optional_fetch(optional_fetch), .optional_free(optional_free),
        .queue_status_pins(queue_status_pins));

    prog_mem_model mem_u (
        .sys_clk(sys_clk), .nrst(nrst), .slow(slow), .fetch_valid(fetch_valid), .fetch_ready(fetch_ready),
        .fetch_addr(fetch_addr), .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_data(mem_data));

    // ----------------------------------------------------------------
    // Clock, fetch counter, helpers
    // ----------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        if (!nrst) n_fetch = 0;
        else if (fetch_valid && fetch_ready) begin
            if (n_fetch == 0) first_addr = fetch_addr;
            n_fetch++;
        end
    end

    function automatic logic [15:0] ew(input logic [15:0] a);
        return {a[7:0], a[15:8] ^ 8'h5A};
    endfunction : ew

    task automatic step(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : step

    // One-cycle control pulse; status pins are settled when it returns, align_odd one cycle later
    task automatic ctl(input logic s, input logic a, input logic t, input logic o);
        {exec_start, exec_advance, exec_toggle_align, exec_optional} = {s, a, t, o};
        @(negedge sys_clk);
        {exec_start, exec_advance, exec_toggle_align, exec_optional} = 4'h0;
    endtask : ctl

    task automatic start(input logic [15:0] vec);
        nrst = 1'b0;
        reset_vector = vec;
        step(3);
        nrst = 1'b1;
        for (int i = 0; i < 40 && queue_ready !== 1'b1; i++) step(1);
        `CHK("queue_ready", 1'b1, queue_ready)
        step(2);
    endtask : start

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_start(input logic [15:0] vec);
        logic [15:0] base, w0, w1;
        logic [23:0] e;
        base = {vec[15:1], 1'b0};
        w0 = ew(base);
        w1 = ew(base + 16'h0002);
        e = vec[0] ? {w0[7:0], w1} : {w0, w1[15:8]};
        start(vec);
        `CHK("first fetch", base, first_addr)
        `CHK("align_odd", vec[0], align_odd)
        `CHK("three bytes", e, {opcode, operand1, operand2})
        ctl(1'b1, 1'b0, 1'b0, 1'b0);
        step(1);
        exec_optional = 1'b1;
        #1;
        `CHK("optional_fetch", vec[0], optional_fetch)
        `CHK("optional_free", !vec[0], optional_free)
        @(negedge sys_clk);
        exec_optional = 1'b0;
    endtask : t_start

    task automatic t_status();
        logic [1:0] code[4] = '{prefetch_pkg::STATUS_IDLE, prefetch_pkg::STATUS_ADVANCE,
                                prefetch_pkg::STATUS_START, prefetch_pkg::STATUS_BOTH};
        logic       a0;
        start(16'h1000);
        for (int i = 0; i < 4; i++) begin
            ctl(i[1], i[0], 1'b0, 1'b0);
            `CHK("status code", code[i], queue_status_pins)
            step(4);
        end
        a0 = align_odd;
        ctl(1'b0, 1'b0, 1'b1, 1'b0);
        // Alignment output trails the internal state by one register
        step(1);
        `CHK("toggled align", !a0, align_odd)
    endtask : t_status

    // Frozen core: no fetch and no queue motion until released
    task automatic t_freeze();
        nrst = 1'b0;
        core_freeze = 1'b1;
        reset_vector = 16'h4002;
        step(3);
        nrst = 1'b1;
        step(5);
        `CHK("frozen fetches", 0, n_fetch)
        ctl(1'b0, 1'b1, 1'b0, 1'b0);
        `CHK("frozen status", prefetch_pkg::STATUS_IDLE, queue_status_pins)
        core_freeze = 1'b0;
        step(10);
        `CHK("thawed first fetch", 16'h4002, first_addr)
    endtask : t_freeze

    // Slow memory: fill stops at queue size, each advance buys one refill
    task automatic t_refill();
        slow = 1'b1;
        start(16'h3000);
        step(10);
        `CHK("fill count", prefetch_pkg::QUEUE_WORDS, n_fetch)
        `CHK("mem_ready", 1'b1, mem_ready)
        ctl(1'b0, 1'b1, 1'b0, 1'b0);
        step(1);
        ctl(1'b0, 1'b1, 1'b0, 1'b0);
        step(20);
        `CHK("refill count", prefetch_pkg::QUEUE_WORDS + 2, n_fetch)
        slow = 1'b0;
    endtask : t_refill

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #20000;
        n_fail++;
        report_and_stop();
    end

    initial begin
        {nrst, slow, core_freeze, exec_start, exec_advance, exec_toggle_align, exec_optional} = 7'h00;
        reset_vector = 16'h0000;
        n_fail = 0;
        samples_checked = 0;
        t_start(16'h1000);
        t_start(16'h2001);
        t_status();
        t_freeze();
        t_refill();
        report_and_stop();
    end
endmodule : instruction_prefetch_queue_tb_top
